// ### hw/aurx_pkg.sv
// Purpose: Constants for the asynchronous receive recovery block.
// Assumes: One 20 MHz system clock, sample tick from an outside divider.
// Notes: Register offsets are word byte addresses on the plain port.
//
// Function
// - Disabling the receiver empties the receive buffer, discarding unread characters.
// - Sample the line 16 times per bit, or 8 in double speed.
// - A high to low transition starts detection; first low sample is one.
// - Validate start on samples 8,9,10 normally or 4,5,6 in double speed.
// - Two or more high qualification samples reject start as noise.
// - Resynchronise sampling phase on every accepted start bit.
// - Sequencer has 16 states per bit, 8 in double speed.
// - Each data or parity bit is the majority of three centre samples.
// - Recover through the first stop bit; ignore further stop bits.
// - First stop bit voted the same; zero sets the frame error flag.
// - New start may be seen right after the last stop voting sample.
// - Data plus parity bits total from 5 to 10.
// - Double speed halves ticks per bit from 16 to 8, async only.
// - Receive buffer is a two-entry queue; reading data advances it.
// - With parity check enabled, compare computed and received parity, store result.
package aurx_pkg;
   // Register byte addresses
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STAT = 5'h04;
   localparam logic [4:0] REG_DATA = 5'h08;
   localparam logic [4:0] REG_IRQ = 5'h0C;
   localparam logic [4:0] REG_MASK = 5'h10;
   // Control fields
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_DS_BIT  = 1;
   localparam int CTRL_PE_BIT  = 2;
   localparam int CTRL_ODD_BIT = 3;
   localparam int CTRL_LEN_LSB = 4;
   localparam logic [3:0] CTRL_LEN_RST = 4'h8;
   localparam logic [3:0] LEN_MIN = 4'h5;
   localparam logic [3:0] LEN_MAX = 4'hA;
   // Sample timing
   localparam logic [3:0] SPB_NORM_M1 = 4'hF;
   localparam logic [3:0] SPB_DS_M1   = 4'h7;
   localparam logic [3:0] MID_NORM = 4'h9;
   localparam logic [3:0] MID_DS   = 4'h5;
   // Interrupt status bits
   localparam int IRQ_RXC = 0;
   localparam int IRQ_FE  = 1;
   localparam int IRQ_PE  = 2;
   localparam int IRQ_OVR = 3;
   localparam int IRQ_W   = 4;
   typedef enum logic [1:0] {
      AURX_IDLE  = 2'b00,
      AURX_START = 2'b01,
      AURX_BITS  = 2'b10
   } aurx_state_t;
endpackage

// ### hw/aurx_top.sv
// Purpose: Oversampling asynchronous receiver with two-entry receive queue.
// Assumes: sample_tick is one clk pulse at 16x (or 8x) the bit rate.
// Notes: Frame length counts data plus parity bits.
`timescale 1ns/1ps
`default_nettype none
module aurx_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial side
   input wire logic serial_receive_pin,
   input wire logic sample_tick,
   // Register port
   input wire logic [4:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Interrupt
   output logic irq
);
   // ********************************************
   // Synchroniser and control
   // ********************************************
   logic sync1_r, sync2_r, rx_prev_r;
   logic [7:0] ctrl_r;
   logic receiver_enable, double_speed_select, parity_check_enable, odd_par;
   logic [3:0] frame_len;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         rx_prev_r <= 1'b1;
      end else begin
         sync1_r <= serial_receive_pin;
         sync2_r <= sync1_r;
         if (sample_tick)
            rx_prev_r <= sync2_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ctrl_r <= {aurx_pkg::CTRL_LEN_RST, 4'h0};
      else if (wr && addr == aurx_pkg::REG_CTRL)
         ctrl_r <= wdata[7:0];
   end

   assign receiver_enable = ctrl_r[aurx_pkg::CTRL_EN_BIT];
   assign double_speed_select = ctrl_r[aurx_pkg::CTRL_DS_BIT];
   assign parity_check_enable = ctrl_r[aurx_pkg::CTRL_PE_BIT];
   assign odd_par = ctrl_r[aurx_pkg::CTRL_ODD_BIT];
   // Out-of-range lengths clamp so the sequencer always ends
   always_comb begin
      frame_len = ctrl_r[aurx_pkg::CTRL_LEN_LSB +: 4];
      if (frame_len < aurx_pkg::LEN_MIN)
         frame_len = aurx_pkg::LEN_MIN;
      else if (frame_len > aurx_pkg::LEN_MAX)
         frame_len = aurx_pkg::LEN_MAX;
   end

   // ********************************************
   // Clock and data recovery
   // ********************************************
   aurx_pkg::aurx_state_t state_r;
   logic [3:0] phase_r;
   logic [3:0] bitn_r;
   logic [2:0] vote_r;
   logic [10:0] shift_r;
   logic frame_done_r, frame_fe_r;
   logic [3:0] last_ph, mid_ph;
   logic vote_bit;

   assign last_ph = double_speed_select ? aurx_pkg::SPB_DS_M1
                                        : aurx_pkg::SPB_NORM_M1;
   assign mid_ph = double_speed_select ? aurx_pkg::MID_DS
                                       : aurx_pkg::MID_NORM;

   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // Vote includes the sample taken this tick at mid+1
   assign vote_bit = maj3({vote_r[1:0], sync2_r});

   // Phase numbers the sample; phase 1 is the first low sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= aurx_pkg::AURX_IDLE;
         phase_r <= 4'h0;
         bitn_r <= 4'h0;
         vote_r <= 3'h0;
         shift_r <= 11'h0;
         frame_done_r <= 1'b0;
         frame_fe_r <= 1'b0;
      end else begin
         frame_done_r <= 1'b0;
         if (!receiver_enable) begin
            state_r <= aurx_pkg::AURX_IDLE;
         end else if (sample_tick) begin
            vote_r <= {vote_r[1:0], sync2_r};
            case (state_r)
               aurx_pkg::AURX_IDLE: begin
                  if (rx_prev_r && !sync2_r) begin
                     state_r <= aurx_pkg::AURX_START;
                     phase_r <= 4'h1;
                  end
               end
               aurx_pkg::AURX_START: begin
                  phase_r <= phase_r + 4'h1;
                  if (phase_r == mid_ph) begin
                     if (vote_bit) begin
                        state_r <= aurx_pkg::AURX_IDLE;
                     end else begin
                        state_r <= aurx_pkg::AURX_BITS;
                        bitn_r <= 4'h0;
                     end
                  end
               end
               aurx_pkg::AURX_BITS: begin
                  // Bit boundaries sit at phase wrap, 16 or 8 states
                  phase_r <= (phase_r == last_ph) ? 4'h0
                                                  : phase_r + 4'h1;
                  if (phase_r == mid_ph) begin
                     shift_r <= {vote_bit, shift_r[10:1]};
                     if (bitn_r == frame_len) begin
                        // First stop bit only; later ones look idle
                        state_r <= aurx_pkg::AURX_IDLE;
                        frame_done_r <= 1'b1;
                        frame_fe_r <= ~vote_bit;
                     end else begin
                        bitn_r <= bitn_r + 4'h1;
                     end
                  end
               end
               default: state_r <= aurx_pkg::AURX_IDLE;
            endcase
         end
      end
   end
   // Return to idle right after the stop vote allows an immediate start

   // ********************************************
   // Character assembly and parity
   // ********************************************
   logic [10:0] aligned;
   logic [9:0] dbits;
   logic [9:0] char_bits;
   logic par_rx, par_err;

   // Frame sits in top frame_len+1 bits of shift_r
   assign aligned = shift_r >> (4'hA - frame_len);
   // Stop bit sits just above the character; keep it out of the data
   assign dbits = aligned[9:0] & ((10'h1 << frame_len) - 10'h1);
   always_comb begin
      char_bits = dbits;
      par_rx = 1'b0;
      if (parity_check_enable) begin
         par_rx = dbits[frame_len - 4'h1];
         char_bits[frame_len - 4'h1] = 1'b0;
      end
   end
   // Even parity: data xor parity bit is zero
   assign par_err = parity_check_enable &
                    ((^char_bits) ^ par_rx ^ odd_par);

   // ********************************************
   // Two-entry receive queue
   // ********************************************
   logic [11:0] q_r [0:1];
   logic [1:0] cnt_r;
   logic ovr_r;
   logic pop;
   logic flush;
   logic [11:0] entry;

   // Disable write flushes at once, so a status read right after sees empty
   assign flush = !receiver_enable ||
                  (wr && addr == aurx_pkg::REG_CTRL &&
                   !wdata[aurx_pkg::CTRL_EN_BIT]);

   assign pop = rd && addr == aurx_pkg::REG_DATA && cnt_r != 2'h0;
   assign entry = {par_err, frame_fe_r, char_bits};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 2'h0;
         q_r[0] <= 12'h0;
         q_r[1] <= 12'h0;
         ovr_r <= 1'b0;
      end else if (flush) begin
         cnt_r <= 2'h0;
         ovr_r <= 1'b0;
      end else begin
         if (pop) begin
            q_r[0] <= q_r[1];
         end
         if (frame_done_r) begin
            if (cnt_r == 2'h2 && !pop) begin
               ovr_r <= 1'b1;
            end else begin
               ovr_r <= 1'b0;
               if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop))
                  q_r[0] <= entry;
               else
                  q_r[1] <= entry;
            end
         end
         case ({frame_done_r && !(cnt_r == 2'h2 && !pop), pop})
            2'b10: cnt_r <= cnt_r + 2'h1;
            2'b01: cnt_r <= cnt_r - 2'h1;
            default: cnt_r <= cnt_r;
         endcase
      end
   end

   // ********************************************
   // Interrupts and read port
   // ********************************************
   logic [3:0] ists_r, imask_r, ev;
   logic frame_ovr;

   assign frame_ovr = frame_done_r && cnt_r == 2'h2 && !pop;
   assign ev = {frame_ovr, frame_done_r & par_err,
                frame_done_r & frame_fe_r, frame_done_r};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         imask_r <= 4'h0;
      else if (wr && addr == aurx_pkg::REG_MASK)
         imask_r <= wdata[3:0];
   end

   // Set wins over write-one-to-clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ists_r <= 4'h0;
      else if (wr && addr == aurx_pkg::REG_IRQ)
         ists_r <= (ists_r & ~wdata[3:0]) | ev;
      else
         ists_r <= ists_r | ev;
   end

   assign irq = |(ists_r & imask_r);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0;
      end else if (rd) begin
         case (addr)
            aurx_pkg::REG_CTRL: rdata <= {24'h0, ctrl_r};
            // Head error bits read zero once the queue is empty
            aurx_pkg::REG_STAT: rdata <= {25'h0, ovr_r,
                                          q_r[0][11:10] & {2{cnt_r != 2'h0}},
                                          state_r != aurx_pkg::AURX_IDLE,
                                          cnt_r, cnt_r != 2'h0};
            aurx_pkg::REG_DATA: rdata <= {22'h0, q_r[0][9:0]};
            aurx_pkg::REG_IRQ: rdata <= {28'h0, ists_r};
            aurx_pkg::REG_MASK: rdata <= {28'h0, imask_r};
            default: rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end
endmodule // aurx_top
`default_nettype wire

// ### bench/aurx_tx_model.sv
// Purpose: Remote serial transmitter driving the receive line.
// Assumes: Paced by the same sample tick as the receiver.
// Notes: Line idles high, as with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module aurx_tx_model (
   // Clock and pacing
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [4:0] spb,
   // Frame request
   input wire logic send,
   input wire logic glitch,
   input wire logic [3:0] nbits,
   input wire logic [10:0] bits,
   // Line
   output logic line,
   output logic busy
);
   logic [10:0] sh_r;
   logic [3:0] left_r;
   logic [4:0] cnt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line <= 1'b1;
         busy <= 1'b0;
         sh_r <= 11'h0;
         left_r <= 4'h0;
         cnt_r <= 5'h0;
      end else if (send && !busy) begin
         busy <= 1'b1;
         line <= 1'b0;
         sh_r <= bits;
         left_r <= glitch ? 4'h0 : nbits + 4'h1;
         cnt_r <= glitch ? 5'h3 : spb;
      end else if (busy && tick) begin
         if (cnt_r != 5'h1) begin
            cnt_r <= cnt_r - 5'h1;
         end else if (left_r == 4'h0) begin
            line <= 1'b1;
            busy <= 1'b0;
         end else begin
            line <= sh_r[0];
            sh_r <= sh_r >> 1;
            left_r <= left_r - 4'h1;
            cnt_r <= spb;
         end
      end
   end
endmodule // aurx_tx_model
`default_nettype wire

// ### bench/aurx_asserts.sv
// Purpose: Port-level checks of the receiver register port.
// Assumes: Register map of aurx_pkg.
// Notes: Queue state is only seen through reads.
`timescale 1ns/1ps
`default_nettype none
module aurx_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial side
   input wire logic serial_receive_pin,
   input wire logic sample_tick,
   // Register port
   input wire logic [4:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   rdata_quiet_a: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("rdata without read");
   unmapped_rd_a: assert property (rd && addr[1:0] != 2'h0 |=>
      rdata == 32'h0) else $error("unmapped read not zero");
   queue_count_a: assert property (rd && addr == aurx_pkg::REG_STAT
      |=> rdata[2:1] != 2'h3 && rdata[31:7] == 25'h0)
      else $error("bad queue count");
   rx_flag_a: assert property (rd && addr == aurx_pkg::REG_STAT |=>
      rdata[0] == (rdata[2:1] != 2'h0)) else $error("complete flag");
   err_head_a: assert property (rd && addr == aurx_pkg::REG_STAT |=>
      rdata[0] || rdata[5:4] == 2'h0) else $error("error without data");
   data_width_a: assert property (rd && addr == aurx_pkg::REG_DATA |=>
      rdata[31:10] == 22'h0) else $error("data too wide");
   flush_off_a: assert property (wr && addr == aurx_pkg::REG_CTRL &&
      !wdata[0] ##1 rd && addr == aurx_pkg::REG_STAT |=> rdata[2:0] == 3'h0)
      else $error("queue kept after disable");
   event_bits_a: assert property (rd && addr == aurx_pkg::REG_IRQ |=>
      rdata[31:4] == 28'h0) else $error("event bits too wide");
endmodule // aurx_chk
bind aurx_top aurx_chk aurx_chk_i (.clk(clk), .rst_n(rst_n),
   .serial_receive_pin(serial_receive_pin), .sample_tick(sample_tick),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
`default_nettype wire

// ### bench/testbench.sv
// Purpose: Register-level test of the receiver.
// Assumes: Sample tick every 4 clocks.
// Notes: Mask opened for the frame-done bit to watch the interrupt pin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tick = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic irq;
   logic line;
   logic busy;
   logic send = 1'b0;
   logic glitch = 1'b0;
   logic [3:0] nbits = 4'h8;
   logic [10:0] bits = 11'h0;
   logic [4:0] spb = 5'h10;
   logic [1:0] div_r = 2'h0;
   int fails = 0;
   int n_checks = 0;
   always #25 clk = ~clk;
   always @(posedge clk) begin
      div_r <= div_r + 2'h1;
      tick <= (div_r == 2'h3);
   end
   aurx_top aurx_top_i (.clk(clk), .rst_n(rst_n), .serial_receive_pin(line),
      .sample_tick(tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .irq(irq));
   aurx_tx_model aurx_tx_model_i (.clk(clk), .rst_n(rst_n), .tick(tick),
      .spb(spb), .send(send), .glitch(glitch), .nbits(nbits), .bits(bits),
      .line(line), .busy(busy));
   task automatic end_of_test();
      if (fails == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] m,
         input logic [31:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata & m, e);
   endtask
   // Frame body: character in the low n bits, stop bit above it
   task automatic tx(input int n, input logic [9:0] d, input logic s,
         input logic g);
      int i;
      @(posedge clk);
      send <= 1'b1;
      nbits <= 4'(n);
      bits <= {1'b0, d} | (11'({s}) << n);
      glitch <= g;
      @(posedge clk);
      send <= 1'b0;
      #1 for (i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge clk);
      if (busy !== 1'b0) begin
         fails++;
         end_of_test();
      end
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(aurx_pkg::REG_CTRL, 32'hFF, 32'h80);
      rd_chk(5'h02, 32'hFFFFFFFF, 32'h0);
      wr_reg(aurx_pkg::REG_CTRL, 32'h81);
      tx(8, 10'hA5, 1'b1, 1'b0);
      rd_chk(aurx_pkg::REG_STAT, 32'h7F, 32'h03);
      rd_chk(aurx_pkg::REG_IRQ, 32'h1, 32'h1);
      check({31'h0, irq}, 32'h0);
      wr_reg(aurx_pkg::REG_MASK, 32'h1);
      rd_chk(aurx_pkg::REG_MASK, 32'hF, 32'h1);
      check({31'h0, irq}, 32'h1);
      wr_reg(aurx_pkg::REG_IRQ, 32'h1);
      rd_chk(aurx_pkg::REG_IRQ, 32'h1, 32'h0);
      check({31'h0, irq}, 32'h0);
      rd_chk(aurx_pkg::REG_DATA, 32'h3FF, 32'hA5);
      rd_chk(aurx_pkg::REG_STAT, 32'h1, 32'h0);
      tx(8, 10'h3C, 1'b0, 1'b0);
      rd_chk(aurx_pkg::REG_STAT, 32'h11, 32'h11);
      rd_chk(aurx_pkg::REG_DATA, 32'h3FF, 32'h3C);
      tx(8, 10'h00, 1'b1, 1'b1);
      rd_chk(aurx_pkg::REG_STAT, 32'h1, 32'h0);
      for (int i = 1; i < 4; i++) tx(8, 10'(8'h33 * i), 1'b1, 1'b0);
      rd_chk(aurx_pkg::REG_STAT, 32'h47, 32'h45);
      rd_chk(aurx_pkg::REG_DATA, 32'h3FF, 32'h33);
      rd_chk(aurx_pkg::REG_DATA, 32'h3FF, 32'h66);
      wr_reg(aurx_pkg::REG_CTRL, 32'h83);
      spb <= 5'h8;
      tx(8, 10'hC3, 1'b1, 1'b0);
      rd_chk(aurx_pkg::REG_DATA, 32'h3FF, 32'hC3);
      wr_reg(aurx_pkg::REG_CTRL, 32'h95);
      spb <= 5'h10;
      tx(9, 10'h15A, 1'b1, 1'b0);
      rd_chk(aurx_pkg::REG_STAT, 32'h21, 32'h21);
      rd_chk(aurx_pkg::REG_DATA, 32'h3FF, 32'h5A);
      wr_reg(aurx_pkg::REG_CTRL, 32'h51);
      tx(5, 10'h15, 1'b1, 1'b0);
      rd_chk(aurx_pkg::REG_DATA, 32'h3FF, 32'h15);
      tx(5, 10'h0A, 1'b1, 1'b0);
      wr_reg(aurx_pkg::REG_CTRL, 32'h50);
      rd_chk(aurx_pkg::REG_STAT, 32'h7, 32'h0);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
